// *** intc_defines.svh ***
// Offsets, field positions, reset values and widths of the trap and
// interrupt control registers. Definitions only; include by bare name.
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH

// Register bus geometry
`define INTC_ADDR_W 4
`define INTC_DATA_W 16

// Register offsets
`define INTC_TRAP_FLAGS_OFFSET 4'h0
`define INTC_GLOBAL_EDGE_OFFSET 4'h2
`define INTC_PRIORITY_OFFSET 4'h4

// Trap flags and nesting register fields
`define INTC_NESTING_DISABLE_BIT 15
`define INTC_ACC_A_OVF_BIT 14
`define INTC_ACC_B_OVF_BIT 13
`define INTC_ACC_A_CAT_BIT 12
`define INTC_ACC_B_CAT_BIT 11
`define INTC_ACC_A_TE_BIT 10
`define INTC_ACC_B_TE_BIT 9
`define INTC_CAT_TE_BIT 8
`define INTC_SHIFT_ERR_BIT 7
`define INTC_DIV_ZERO_BIT 6
`define INTC_MATH_ERR_BIT 4
`define INTC_ADDR_ERR_BIT 3
`define INTC_STACK_ERR_BIT 2
`define INTC_OSC_FAIL_BIT 1

// Global enable and edge select register fields
`define INTC_GLOBAL_EN_BIT 15
`define INTC_TIMED_IRQ_DISABLE_ACTIVE_BIT 14
`define INTC_SW_TRAP_BIT 13
`define INTC_ALT_VECTOR_BIT 8
`define INTC_POLARITY_LSB 0

// Priority register field
`define INTC_LEVEL_LSB 0

// Reset values
`define INTC_GLOBAL_EN_RESET 1'b1
`define INTC_CONTROL_RESET 1'b0
`define INTC_LEVEL_RESET 3'h0
`define INTC_DEPTH_RESET 3'h0
`define INTC_POLARITY_RESET 3'h0

// Counts
`define INTC_TRAP_FLAG_COUNT 10
`define INTC_EXT_IRQ_COUNT 3

`endif

// *** intc_pkg.sv ***
// Types shared by the interrupt and trap control block.
// Assumes intc_defines.svh is on the include path.
`include "intc_defines.svh"

package intc_pkg;

  typedef logic [`INTC_DATA_W-1:0] word_type;
  typedef logic [`INTC_ADDR_W-1:0] addr_type;
  typedef logic [2:0] level_type;
  typedef logic [`INTC_EXT_IRQ_COUNT-1:0] ext_vec_type;
  typedef logic [`INTC_TRAP_FLAG_COUNT-1:0] trap_vec_type;

endpackage : intc_pkg

// *** sticky_flag.sv ***
// One trap status flag: hardware sets it, software writes it.
// Assumes the set event and the write come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

module sticky_flag
(
  input wire logic clk,
  input wire logic srst,
  input wire logic set_event,
  input wire logic wr_en,
  input wire logic wr_value,
  output var logic flag
);

  // A set arriving with a software clear wins, so no event is lost
  always_ff @(posedge clk)
  begin
    if (srst)
      flag <= 1'b0;
    else if (set_event)
      flag <= 1'b1;
    else if (wr_en)
      flag <= wr_value;
  end

endmodule : sticky_flag

`default_nettype wire

// *** ext_edge_detect.sv ***
// Edge detector for one external interrupt pin with selectable polarity.
// Assumes the pin is asynchronous to clk; it passes two flip-flops first.
`timescale 1ns/1ps
`default_nettype none

module ext_edge_detect
(
  input wire logic clk,
  input wire logic srst,
  input wire logic pin,
  input wire logic falling_sel,
  output var logic edge_pulse
);

  logic sync_a;
  logic sync_b;
  logic prev;

  // Two-stage synchroniser; only sync_b is looked at
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      sync_a <= pin;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  // Polarity 1 picks a falling edge, 0 a rising edge
  always_ff @(posedge clk)
  begin
    if (srst)
      edge_pulse <= 1'b0;
    else if (falling_sel)
      edge_pulse <= prev & ~sync_b;
    else
      edge_pulse <= ~prev & sync_b;
  end

endmodule : ext_edge_detect

`default_nettype wire

// *** intc_ctrl.sv ***
// Interrupt and trap control registers with trap flag capture,
// interrupt acceptance, nesting control and external edge detection.
// Assumes the core, its math unit and peripherals run on clk; the
// external interrupt pins are asynchronous.
//
// Functional notes
// - Nesting disabled blocks preemption of running handler
// - Accumulator A overflow trap sets its flag
// - Accumulator B overflow trap sets its flag
// - Accumulator A catastrophic overflow sets its flag
// - Accumulator B catastrophic overflow sets its flag
// - Per-accumulator enables gate overflow traps
// - One enable gates both catastrophic overflow traps
// - Invalid shift math trap sets shift flag
// - Divide by zero math trap sets flag
// - Math error flag records a math trap
// - Address error trap sets its flag
// - Stack error trap sets its flag
// - Oscillator failure trap sets its flag
// - Global enable gates interrupts, not traps; resets 1
// - Timed disable status bit reads active state
// - Software trap bit enables software trap
// - Alternate table bit selects vector table
// - Polarity bit picks falling or rising edge
// - Unimplemented bits read as zero
// - Priority level read-only while nesting disabled
`timescale 1ns/1ps
`default_nettype none

module intc_ctrl
  import intc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [`INTC_ADDR_W-1:0] reg_addr,
  input wire logic [`INTC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output var logic [`INTC_DATA_W-1:0] reg_rdata,
  // Trap causes from the core, one-cycle pulses
  input wire logic acc_a_overflow_event,
  input wire logic acc_b_overflow_event,
  input wire logic acc_a_catastrophic_event,
  input wire logic acc_b_catastrophic_event,
  input wire logic shift_error_event,
  input wire logic divide_zero_event,
  input wire logic address_error_event,
  input wire logic stack_error_event,
  input wire logic osc_failure_event,
  // Core status
  input wire logic timed_irq_disable_active_in_effect,
  input wire logic handler_return,
  input wire logic [2:0] return_level,
  // Pending peripheral interrupt, already gated by its own enable
  input wire logic periph_irq_pending,
  input wire logic [2:0] periph_irq_level,
  // External interrupt pins
  input wire logic [`INTC_EXT_IRQ_COUNT-1:0] ext_irq_pin,
  // Results
  output var logic trap_take,
  output var logic irq_take,
  output var logic alt_vector_table,
  output var logic [2:0] cpu_priority_level,
  output var logic [`INTC_EXT_IRQ_COUNT-1:0] ext_irq_edge
);

  // Control bits
  logic nesting_disable;
  logic acc_a_overflow_trap_enable;
  logic acc_b_overflow_trap_enable;
  logic catastrophic_trap_enable;
  logic global_irq_enable;
  logic software_trap_control;
  logic [`INTC_EXT_IRQ_COUNT-1:0] ext_irq_polarity;
  logic [2:0] handler_depth;

  // Decoded writes
  logic wr_trap_flags;
  logic wr_global_edge;
  logic wr_priority;

  // Trap event and flag vectors, index 9 down to 0:
  // acc A ovf, acc B ovf, acc A cat, acc B cat, shift, div0,
  // math, address, stack, oscillator
  logic [`INTC_TRAP_FLAG_COUNT-1:0] trap_event;
  logic [`INTC_TRAP_FLAG_COUNT-1:0] trap_flag;
  logic [`INTC_TRAP_FLAG_COUNT-1:0] trap_wr_value;
  logic sw_trap_rise;
  logic next_irq_accept;

  assign wr_trap_flags = reg_wr && (reg_addr == `INTC_TRAP_FLAGS_OFFSET);
  assign wr_global_edge = reg_wr && (reg_addr == `INTC_GLOBAL_EDGE_OFFSET);
  assign wr_priority = reg_wr && (reg_addr == `INTC_PRIORITY_OFFSET);

  // Overflow traps only count when their enable is on
  assign trap_event[9] = acc_a_overflow_event & acc_a_overflow_trap_enable;
  assign trap_event[8] = acc_b_overflow_event & acc_b_overflow_trap_enable;
  assign trap_event[7] = acc_a_catastrophic_event & catastrophic_trap_enable;
  assign trap_event[6] = acc_b_catastrophic_event & catastrophic_trap_enable;
  assign trap_event[5] = shift_error_event;
  assign trap_event[4] = divide_zero_event;
  assign trap_event[3] = shift_error_event | divide_zero_event;
  assign trap_event[2] = address_error_event;
  assign trap_event[1] = stack_error_event;
  assign trap_event[0] = osc_failure_event;

  assign trap_wr_value = {reg_wdata[`INTC_ACC_A_OVF_BIT], reg_wdata[`INTC_ACC_B_OVF_BIT],
                          reg_wdata[`INTC_ACC_A_CAT_BIT], reg_wdata[`INTC_ACC_B_CAT_BIT],
                          reg_wdata[`INTC_SHIFT_ERR_BIT], reg_wdata[`INTC_DIV_ZERO_BIT],
                          reg_wdata[`INTC_MATH_ERR_BIT], reg_wdata[`INTC_ADDR_ERR_BIT],
                          reg_wdata[`INTC_STACK_ERR_BIT], reg_wdata[`INTC_OSC_FAIL_BIT]};

  // One sticky flag per trap cause; the set wins over a software write
  genvar gi;
  generate
    for (gi = 0; gi < `INTC_TRAP_FLAG_COUNT; gi++)
    begin : g_flag
      sticky_flag u_flag
      (
        .clk(clk),
        .srst(srst),
        .set_event(trap_event[gi]),
        .wr_en(wr_trap_flags),
        .wr_value(trap_wr_value[gi]),
        .flag(trap_flag[gi])
      );
    end
  endgenerate

  // External pin edge detectors, polarity per pin
  generate
    for (gi = 0; gi < `INTC_EXT_IRQ_COUNT; gi++)
    begin : g_ext
      ext_edge_detect u_edge
      (
        .clk(clk),
        .srst(srst),
        .pin(ext_irq_pin[gi]),
        .falling_sel(ext_irq_polarity[gi]),
        .edge_pulse(ext_irq_edge[gi])
      );
    end
  endgenerate

  // Control bits of the trap flags register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      nesting_disable <= `INTC_CONTROL_RESET;
      acc_a_overflow_trap_enable <= `INTC_CONTROL_RESET;
      acc_b_overflow_trap_enable <= `INTC_CONTROL_RESET;
      catastrophic_trap_enable <= `INTC_CONTROL_RESET;
    end
    else if (wr_trap_flags)
    begin
      nesting_disable <= reg_wdata[`INTC_NESTING_DISABLE_BIT];
      acc_a_overflow_trap_enable <= reg_wdata[`INTC_ACC_A_TE_BIT];
      acc_b_overflow_trap_enable <= reg_wdata[`INTC_ACC_B_TE_BIT];
      catastrophic_trap_enable <= reg_wdata[`INTC_CAT_TE_BIT];
    end
  end

  // Global enable and edge select register; global enable resets to 1
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      global_irq_enable <= `INTC_GLOBAL_EN_RESET;
      software_trap_control <= `INTC_CONTROL_RESET;
      alt_vector_table <= `INTC_CONTROL_RESET;
      ext_irq_polarity <= `INTC_POLARITY_RESET;
    end
    else if (wr_global_edge)
    begin
      global_irq_enable <= reg_wdata[`INTC_GLOBAL_EN_BIT];
      software_trap_control <= reg_wdata[`INTC_SW_TRAP_BIT];
      alt_vector_table <= reg_wdata[`INTC_ALT_VECTOR_BIT];
      ext_irq_polarity <= reg_wdata[`INTC_POLARITY_LSB +: `INTC_EXT_IRQ_COUNT];
    end
  end

  // Software trap fires once when its enable goes from 0 to 1
  assign sw_trap_rise = wr_global_edge && reg_wdata[`INTC_SW_TRAP_BIT] && !software_trap_control;

  // Traps ignore the global enable and the timed disable
  always_ff @(posedge clk)
  begin
    if (srst)
      trap_take <= 1'b0;
    else
      trap_take <= (|trap_event) | sw_trap_rise;
  end

  // Accept only a higher level, never while a timed disable runs, and
  // never into a running handler when nesting is off
  assign next_irq_accept = global_irq_enable && periph_irq_pending && !timed_irq_disable_active_in_effect
                           && (periph_irq_level > cpu_priority_level)
                           && !(nesting_disable && (handler_depth != 3'h0))
                           && !irq_take;

  always_ff @(posedge clk)
  begin
    if (srst)
      irq_take <= 1'b0;
    else
      irq_take <= next_irq_accept;
  end

  // Handler depth; saturates so a runaway nest cannot wrap to zero
  always_ff @(posedge clk)
  begin
    if (srst)
      handler_depth <= `INTC_DEPTH_RESET;
    else if (next_irq_accept && !handler_return && handler_depth != 3'h7)
      handler_depth <= handler_depth + 3'h1;
    else if (handler_return && !next_irq_accept && handler_depth != 3'h0)
      handler_depth <= handler_depth - 3'h1;
  end

  // Priority level: hardware entry and return first, software writes
  // are dropped while nesting is disabled
  always_ff @(posedge clk)
  begin
    if (srst)
      cpu_priority_level <= `INTC_LEVEL_RESET;
    else if (next_irq_accept)
      cpu_priority_level <= periph_irq_level;
    else if (handler_return)
      cpu_priority_level <= return_level;
    else if (wr_priority && !nesting_disable)
      cpu_priority_level <= reg_wdata[`INTC_LEVEL_LSB +: 3];
  end

  // Read data valid only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else
    begin
      reg_rdata <= '0;
      case (reg_addr)
        `INTC_TRAP_FLAGS_OFFSET:
        begin
          reg_rdata[`INTC_NESTING_DISABLE_BIT] <= nesting_disable;
          reg_rdata[`INTC_ACC_A_OVF_BIT] <= trap_flag[9];
          reg_rdata[`INTC_ACC_B_OVF_BIT] <= trap_flag[8];
          reg_rdata[`INTC_ACC_A_CAT_BIT] <= trap_flag[7];
          reg_rdata[`INTC_ACC_B_CAT_BIT] <= trap_flag[6];
          reg_rdata[`INTC_ACC_A_TE_BIT] <= acc_a_overflow_trap_enable;
          reg_rdata[`INTC_ACC_B_TE_BIT] <= acc_b_overflow_trap_enable;
          reg_rdata[`INTC_CAT_TE_BIT] <= catastrophic_trap_enable;
          reg_rdata[`INTC_SHIFT_ERR_BIT] <= trap_flag[5];
          reg_rdata[`INTC_DIV_ZERO_BIT] <= trap_flag[4];
          reg_rdata[`INTC_MATH_ERR_BIT] <= trap_flag[3];
          reg_rdata[`INTC_ADDR_ERR_BIT] <= trap_flag[2];
          reg_rdata[`INTC_STACK_ERR_BIT] <= trap_flag[1];
          reg_rdata[`INTC_OSC_FAIL_BIT] <= trap_flag[0];
        end
        `INTC_GLOBAL_EDGE_OFFSET:
        begin
          reg_rdata[`INTC_GLOBAL_EN_BIT] <= global_irq_enable;
          reg_rdata[`INTC_TIMED_IRQ_DISABLE_ACTIVE_BIT] <= timed_irq_disable_active_in_effect;
          reg_rdata[`INTC_SW_TRAP_BIT] <= software_trap_control;
          reg_rdata[`INTC_ALT_VECTOR_BIT] <= alt_vector_table;
          reg_rdata[`INTC_POLARITY_LSB +: `INTC_EXT_IRQ_COUNT] <= ext_irq_polarity;
        end
        `INTC_PRIORITY_OFFSET:
          reg_rdata[`INTC_LEVEL_LSB +: 3] <= cpu_priority_level;
        default:
          reg_rdata <= '0;
      endcase
    end
  end

  // Checks

  chk_nest_block: assert property (@(posedge clk) disable iff (srst)
    (nesting_disable && handler_depth != 3'h0) |=> !irq_take)
    else $error("interrupt taken into running handler with nesting off");

  chk_ovf_a_flag: assert property (@(posedge clk) disable iff (srst)
    (acc_a_overflow_event && acc_a_overflow_trap_enable) |=> (trap_flag[9] && trap_take))
    else $error("acc A overflow did not set flag and trap");

  chk_ovf_b_flag: assert property (@(posedge clk) disable iff (srst)
    (acc_b_overflow_event && acc_b_overflow_trap_enable) |=> (trap_flag[8] && trap_take))
    else $error("acc B overflow did not set flag and trap");

  chk_cat_flags: assert property (@(posedge clk) disable iff (srst)
    (catastrophic_trap_enable && (acc_a_catastrophic_event || acc_b_catastrophic_event))
    |=> ((trap_flag[7] || trap_flag[6]) && trap_take))
    else $error("catastrophic overflow did not set a flag");

  chk_ovf_gated: assert property (@(posedge clk) disable iff (srst)
    (!acc_a_overflow_trap_enable && !trap_flag[9] && !wr_trap_flags) |=> !trap_flag[9])
    else $error("acc A overflow flag set while its trap is disabled");

  chk_math_flags: assert property (@(posedge clk) disable iff (srst)
    (shift_error_event || divide_zero_event)
    |=> (trap_flag[3] && trap_take && (trap_flag[5] || trap_flag[4])))
    else $error("math error cause did not set its flags");

  chk_sys_flags: assert property (@(posedge clk) disable iff (srst)
    (address_error_event || stack_error_event || osc_failure_event)
    |=> ((trap_flag[2] || trap_flag[1] || trap_flag[0]) && trap_take))
    else $error("system trap did not set its flag");

  chk_global_gate: assert property (@(posedge clk) disable iff (srst)
    !global_irq_enable |=> !irq_take)
    else $error("interrupt taken with global enable off");

  // Only the cycle right after a write-free cycle is judged; a write one
  // cycle later may clear legally
  chk_sticky_hold: assert property (@(posedge clk) disable iff (srst)
    !wr_trap_flags |=> ((trap_flag & $past(trap_flag)) == $past(trap_flag)))
    else $error("trap flag dropped without a write");

  chk_level_lock: assert property (@(posedge clk) disable iff (srst)
    (wr_priority && nesting_disable && !next_irq_accept && !handler_return)
    |=> $stable(cpu_priority_level))
    else $error("priority level changed by software while nesting off");

  chk_read_zero: assert property (@(posedge clk) disable iff (srst)
    (reg_rd && reg_addr == `INTC_GLOBAL_EDGE_OFFSET) |=> (reg_rdata[12:9] == 4'h0
    && reg_rdata[7:3] == 5'h00))
    else $error("unimplemented bits read nonzero");

  chk_edge_lag: assert property (@(posedge clk) disable iff (srst)
    (wr_global_edge && !reg_wdata[`INTC_POLARITY_LSB]) ##1 (!ext_irq_pin[0]) [*4]
    |=> !ext_irq_edge[0])
    else $error("rising polarity pin 0 pulsed while pin stayed low");

endmodule : intc_ctrl

`default_nettype wire

// *** core_side_model.sv ***
// Behavioural core, math unit and interrupt sources facing intc_ctrl.
// Assumes one clock; every output changes just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module core_side_model
  import intc_pkg::*;
(
  input wire logic clk,
  output var logic [8:0] cause,
  output var logic timed_irq_disable_active_on,
  output var logic ret_pulse,
  output var logic [2:0] ret_level,
  output var logic req_pending,
  output var logic [2:0] req_level,
  output var ext_vec_type pins
);
  // Quiet sources at time zero so nothing fires during reset
  initial
  begin
    cause = '0;
    timed_irq_disable_active_on = 1'b0;
    ret_pulse = 1'b0;
    ret_level = '0;
    req_pending = 1'b0;
    req_level = '0;
    pins = '0;
  end

  // One-cycle trap causes, several may fire together; bit order follows
  // the event ports
  task automatic fire(input logic [8:0] mask);
    @(posedge clk);
    cause <= mask;
    @(posedge clk);
    cause <= '0;
  endtask : fire

  // Request held one cycle only, so a repeat accept is never possible
  task automatic request(input logic [2:0] lvl);
    @(posedge clk);
    req_pending <= 1'b1;
    req_level <= lvl;
    @(posedge clk);
    req_pending <= 1'b0;
    req_level <= ~lvl;
  endtask : request

  task automatic handler_done(input logic [2:0] lvl);
    @(posedge clk);
    ret_pulse <= 1'b1;
    ret_level <= lvl;
    @(posedge clk);
    ret_pulse <= 1'b0;
    ret_level <= ~lvl;
  endtask : handler_done

  task automatic pin_to(input int idx, input logic v);
    @(posedge clk);
    pins[idx] <= v;
  endtask : pin_to

  // Timed disable level; called just after an edge, so it changes off the sample
  task automatic set_timed_irq_disable_active(input logic v);
    timed_irq_disable_active_on <= v;
  endtask : set_timed_irq_disable_active
endmodule : core_side_model

`default_nettype wire

// *** test_interrupt_trap_control_regs.sv ***
// Self-checking bench for intc_ctrl driven through its register port.
// Assumes core_side_model plays the core and the interrupt sources.
`timescale 1ns/1ps
`default_nettype none
`include "intc_defines.svh"

module test_interrupt_trap_control_regs
  import intc_pkg::*;
;
  logic clk;
  logic srst;
  addr_type reg_addr;
  word_type reg_wdata;
  logic reg_wr;
  logic reg_rd;
  word_type reg_rdata;
  logic [8:0] cause;
  logic timed_irq_disable_active_on;
  logic ret_pulse;
  logic [2:0] ret_level;
  logic req_pending;
  logic [2:0] req_level;
  ext_vec_type pins;
  logic trap_take;
  logic irq_take;
  logic alt_vector_table;
  logic [2:0] cpu_priority_level;
  ext_vec_type ext_irq_edge;
  int n_errors = 0;
  int tests_run = 0;
  word_type d;
  word_type flag_of [0:8] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0090,
    16'h0050, 16'h0008, 16'h0004, 16'h0002};
  localparam addr_type A_TRAP = `INTC_TRAP_FLAGS_OFFSET;
  localparam addr_type A_GLB = `INTC_GLOBAL_EDGE_OFFSET;
  localparam addr_type A_PRI = `INTC_PRIORITY_OFFSET;

  intc_ctrl dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_a_overflow_event(cause[0]), .acc_b_overflow_event(cause[1]),
    .acc_a_catastrophic_event(cause[2]), .acc_b_catastrophic_event(cause[3]),
    .shift_error_event(cause[4]), .divide_zero_event(cause[5]),
    .address_error_event(cause[6]), .stack_error_event(cause[7]),
    .osc_failure_event(cause[8]), .timed_irq_disable_active_in_effect(timed_irq_disable_active_on),
    .handler_return(ret_pulse), .return_level(ret_level),
    .periph_irq_pending(req_pending), .periph_irq_level(req_level),
    .ext_irq_pin(pins), .trap_take(trap_take), .irq_take(irq_take),
    .alt_vector_table(alt_vector_table), .cpu_priority_level(cpu_priority_level),
    .ext_irq_edge(ext_irq_edge));

  core_side_model core (.clk(clk), .cause(cause), .timed_irq_disable_active_on(timed_irq_disable_active_on),
    .ret_pulse(ret_pulse), .ret_level(ret_level), .req_pending(req_pending),
    .req_level(req_level), .pins(pins));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input word_type seen, input word_type want);
    tests_run++;
    if (seen !== want)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Returns at the edge that takes the write, so outputs are judged 1 ns later
  task automatic wr(input addr_type a, input word_type v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input addr_type a, output word_type v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // Run takes well under a thousand cycles; this only cuts a hang
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    srst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd(A_TRAP, d); check(d, 16'h0000);
    rd(A_GLB, d); check(d, 16'h8000);
    rd(4'h6, d); check(d, 16'h0000);
    wr(A_TRAP, 16'hffff);
    rd(A_TRAP, d); check(d, 16'hffde);
    wr(A_GLB, 16'hffff);
    #1 check(word_type'(trap_take), 16'h0001);
    check(word_type'(alt_vector_table), 16'h0001);
    rd(A_GLB, d); check(d, 16'ha107);
    wr(A_GLB, 16'h8000);
    #1 check(word_type'(alt_vector_table), 16'h0000);
    // Every cause with all enables on, then cleared by software
    wr(A_TRAP, 16'h0700);
    for (int i = 0; i < 9; i++)
    begin
      core.fire(9'h001 << i);
      #1 check(word_type'(trap_take), 16'h0001);
      rd(A_TRAP, d); check(d, 16'h0700 | flag_of[i]);
      rd(A_TRAP, d); check(d, 16'h0700 | flag_of[i]);
      wr(A_TRAP, 16'h0700);
    end
    // Shift and divide by zero in one cycle share the math flag
    core.fire(9'h030);
    rd(A_TRAP, d); check(d, 16'h07d0);
    // Overflow and catastrophic causes with their enables off
    wr(A_TRAP, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      core.fire(9'h001 << i);
      #1 check(word_type'(trap_take), 16'h0000);
      rd(A_TRAP, d); check(d, 16'h0000);
    end
    // Global enable off blocks interrupts but not traps
    wr(A_GLB, 16'h0000);
    core.request(3'd3);
    #1 check(word_type'(irq_take), 16'h0000);
    core.fire(9'h020);
    #1 check(word_type'(trap_take), 16'h0001);
    wr(A_TRAP, 16'h0000);
    wr(A_GLB, 16'h8000);
    core.set_timed_irq_disable_active(1'b1);
    rd(A_GLB, d); check(d, 16'hc000);
    core.request(3'd3);
    #1 check(word_type'(irq_take), 16'h0000);
    core.set_timed_irq_disable_active(1'b0);
    // Nesting allowed: a higher level preempts
    core.request(3'd3);
    #1 check(word_type'(irq_take), 16'h0001);
    check(word_type'(cpu_priority_level), 16'h0003);
    core.request(3'd5);
    #1 check(word_type'(irq_take), 16'h0001);
    check(word_type'(cpu_priority_level), 16'h0005);
    core.handler_done(3'd3);
    core.handler_done(3'd0);
    // Nesting disabled: no preemption and the level is locked
    wr(A_TRAP, 16'h8000);
    core.request(3'd2);
    #1 check(word_type'(irq_take), 16'h0001);
    core.request(3'd6);
    #1 check(word_type'(irq_take), 16'h0000);
    wr(A_PRI, 16'h0000);
    rd(A_PRI, d); check(d, 16'h0002);
    core.handler_done(3'd0);
    core.request(3'd6);
    #1 check(word_type'(irq_take), 16'h0001);
    core.handler_done(3'd0);
    wr(A_TRAP, 16'h0000);
    wr(A_PRI, 16'h0006);
    #1 check(word_type'(cpu_priority_level), 16'h0006);
    wr(A_PRI, 16'h0000);
    // Each pin with each polarity, rising then falling
    for (int i = 0; i < 3; i++)
    begin
      for (int p = 0; p < 2; p++)
      begin
        wr(A_GLB, 16'h8000 | word_type'(p << i));
        core.pin_to(i, 1'b1);
        repeat (3) @(posedge clk);
        #1 check(word_type'(ext_irq_edge), (p == 0) ? word_type'(1 << i) : 16'h0);
        core.pin_to(i, 1'b0);
        repeat (3) @(posedge clk);
        #1 check(word_type'(ext_irq_edge), (p == 1) ? word_type'(1 << i) : 16'h0);
      end
    end
    tally_and_finish();
  end
endmodule : test_interrupt_trap_control_regs

`default_nettype wire
